// ==== core/mmc_axis_hold.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one axis: last value store and threshold compare
module mmc_axis_hold #(
  parameter int W     = 15,
  parameter int TW    = 8,
  parameter int SHIFT = 4
) (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic          ce,
  input  wire logic          clr,
  input  wire logic          upd,
  input  wire logic [W-1:0]  din,
  input  wire logic [TW-1:0] thr_low,
  input  wire logic [TW-1:0] thr_high,
  output logic      [W-1:0]  dout,
  output logic               below,
  output logic               above
);

  logic [W-1:0] hold_ff;
  logic         below_ff;
  logic         above_ff;

  wire logic [W-1:0] nxt_hold = clr ? '0 : (upd ? din : hold_ff);
  wire logic signed [W-1:0] low_lim  = W'($signed(thr_low))  <<< SHIFT;
  wire logic signed [W-1:0] high_lim = W'($signed(thr_high)) <<< SHIFT;
  // compare runs on the held value whether upd is set or not; clr forces both flags low
  wire logic nxt_below = !clr && ($signed(hold_ff) < low_lim);
  wire logic nxt_above = !clr && ($signed(hold_ff) > high_lim);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hold_ff  <= '0;
      below_ff <= 1'b0;
      above_ff <= 1'b0;
    end else if (ce) begin
      hold_ff  <= nxt_hold;
      below_ff <= nxt_below;
      above_ff <= nxt_above;
    end
  end

  assign dout  = hold_ff;
  assign below = below_ff;
  assign above = above_ff;

endmodule : mmc_axis_hold
`default_nettype wire

// ==== core/mmc_ctrl_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmc_ctrl_regs (
  input  wire logic                                   clk_sys,
  input  wire logic                                   reset_n,
  input  wire logic                                   ce,
  input  wire mmc_pkg::mmc_reg_req_t                  reg_req,
  output logic [7:0]                                  reg_rdata,
  input  wire logic                                   spi_sel_pin,
  input  wire mmc_pkg::mmc_meas_t                     meas,
  input  wire logic                                   overrun_evt,
  input  wire logic                                   overflow_evt,
  input  wire logic [2:0]                             chan_off,
  input  wire logic                                   int_latch,
  input  wire logic                                   int_pol,
  input  wire logic                                   int_pin_en,
  input  wire logic [mmc_pkg::THR_W-1:0]              thr_low,
  input  wire logic [mmc_pkg::THR_W-1:0]              thr_high,
  output logic                                        suspended,
  output logic [1:0]                                  op_mode,
  output logic [mmc_pkg::RATE_W-1:0]                  rate_hz,
  output logic [1:0]                                  adv_selftest,
  output logic                                        selftest,
  output logic                                        three_wire,
  output logic [2:0][mmc_pkg::AXIS_W-1:0]             data_axis,
  output logic [mmc_pkg::RHALL_W-1:0]                 rhall,
  output logic                                        int_pin
);

  // ==========================================================
  // state
  mmc_pkg::mmc_pstate_t          pstate_ff;
  mmc_pkg::mmc_pstate_t          nxt_pstate;
  logic [7:0]                    pwr_ctrl_ff;
  logic [7:0]                    mode_ctrl_ff;
  logic [7:0]                    irq_en_ff;
  logic [7:0]                    int_stat_ff;
  logic [7:0]                    rdata_ff;
  logic [mmc_pkg::RATE_W-1:0]    rate_ff;
  logic                          three_wire_ff;
  logic                          int_pin_ff;
  logic [mmc_pkg::RHALL_W-1:0]   rhall_ff;
  logic                          spi_meta_ff;
  logic                          spi_sync_ff;
  logic [2:0]                    below;
  logic [2:0]                    above;

  // ==========================================================
  // decode
  wire logic st_suspend = pstate_ff == mmc_pkg::PS_SUSPEND;
  wire logic st_awake   = pstate_ff == mmc_pkg::PS_AWAKE;
  wire logic st_srst    = pstate_ff == mmc_pkg::PS_SRST;
  wire logic regs_clr   = st_suspend | st_srst;

  wire logic hit_stat = reg_req.addr == mmc_pkg::ADDR_INT_STAT;
  wire logic hit_pwr  = reg_req.addr == mmc_pkg::ADDR_PWR_CTRL;
  wire logic hit_mode = reg_req.addr == mmc_pkg::ADDR_MODE_CTRL;
  wire logic hit_irq  = reg_req.addr == mmc_pkg::ADDR_IRQ_EN;

  wire logic wr_pwr  = reg_req.wr & hit_pwr;
  wire logic wr_mode = reg_req.wr & hit_mode & st_awake;
  wire logic wr_irq  = reg_req.wr & hit_irq & st_awake;
  wire logic rd_stat = reg_req.rd & hit_stat & st_awake;

  wire logic trig_both = pwr_ctrl_ff[mmc_pkg::PWR_SRST_HI]
                       & pwr_ctrl_ff[mmc_pkg::PWR_SRST_LO];
  wire logic pwr_on    = pwr_ctrl_ff[mmc_pkg::PWR_ON];

  // ==========================================================
  // power state
  always_comb begin
    nxt_pstate = pstate_ff;
    unique case (pstate_ff)
      mmc_pkg::PS_SUSPEND: begin
        if (pwr_on) nxt_pstate = mmc_pkg::PS_AWAKE;
      end
      mmc_pkg::PS_AWAKE: begin
        if (!pwr_on) nxt_pstate = mmc_pkg::PS_SUSPEND;
        else if (trig_both) nxt_pstate = mmc_pkg::PS_SRST;
      end
      mmc_pkg::PS_SRST: begin
        nxt_pstate = mmc_pkg::PS_AWAKE;
      end
      default: nxt_pstate = mmc_pkg::PS_SUSPEND;
    endcase
  end

  // ==========================================================
  // power/reset/interface register
  // trigger bits stored only while awake, cleared when reset completes
  wire logic [7:0] pwr_wr_val = reg_req.wdata & mmc_pkg::PWR_WR_MASK;
  // stale trigger bits must not fire after a later wake
  wire logic       trig_keep  = st_awake;
  wire logic       trig_take  = wr_pwr & st_awake;
  wire logic [7:0] nxt_pwr_ctrl = {
    trig_take ? pwr_wr_val[7] : (trig_keep & pwr_ctrl_ff[7]),
    4'h0,
    wr_pwr ? pwr_wr_val[2] : pwr_ctrl_ff[2],
    trig_take ? pwr_wr_val[1] : (trig_keep & pwr_ctrl_ff[1]),
    wr_pwr ? pwr_wr_val[0] : pwr_ctrl_ff[0]
  };

  // ==========================================================
  // mode and threshold enable registers
  wire logic [7:0] nxt_mode_ctrl = regs_clr ? mmc_pkg::RST_MODE_CTRL
                                 : (wr_mode ? reg_req.wdata : mode_ctrl_ff);
  wire logic [7:0] nxt_irq_en    = regs_clr ? mmc_pkg::RST_IRQ_EN
                                 : (wr_irq ? reg_req.wdata : irq_en_ff);

  wire logic [2:0] rate_code = mode_ctrl_ff[mmc_pkg::MODE_RATE_LO +: 3];
  wire logic [mmc_pkg::RATE_W-1:0] nxt_rate = mmc_pkg::mmc_rate_hz(rate_code);

  wire logic nxt_three_wire = spi_sync_ff & pwr_ctrl_ff[mmc_pkg::PWR_3W];

  // ==========================================================
  // per-axis hold and threshold compare
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      mmc_axis_hold #(
        .W     (mmc_pkg::AXIS_W),
        .TW    (mmc_pkg::THR_W),
        .SHIFT (mmc_pkg::THR_SHIFT)
      ) u_hold (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .ce       (ce),
        .clr      (regs_clr),
        .upd      (meas.valid & !chan_off[gi] & st_awake),
        .din      (meas.axis[gi]),
        .thr_low  (thr_low),
        .thr_high (thr_high),
        .dout     (data_axis[gi]),
        .below    (below[gi]),
        .above    (above[gi])
      );
    end
  endgenerate

  // resistance stops and reads zero with z off
  wire logic [mmc_pkg::RHALL_W-1:0] nxt_rhall =
      (regs_clr | chan_off[2]) ? '0
    : (meas.valid ? meas.rhall : rhall_ff);

  // ==========================================================
  // interrupt status
  wire logic [2:0] hi_en = ~irq_en_ff[mmc_pkg::IRQ_HI_LO +: 3];
  wire logic [2:0] lo_en = ~irq_en_ff[mmc_pkg::IRQ_LO_LO +: 3];
  wire logic       ovr_c = overrun_evt & irq_en_ff[mmc_pkg::IRQ_OVR_EN];
  wire logic [7:0] cond  = {ovr_c, overflow_evt, above & hi_en, below & lo_en};
  // latched flags hold until a status read; a new event beats the clear
  wire logic [7:0] stat_kept = (int_latch && !rd_stat) ? int_stat_ff : 8'h00;
  wire logic [7:0] nxt_int_stat = regs_clr ? mmc_pkg::RST_INT_STAT
                                : (cond & {8{st_awake}}) | stat_kept;

  wire logic int_active = (|int_stat_ff[5:0])
                        | (int_stat_ff[mmc_pkg::STAT_OVF]
                           & irq_en_ff[mmc_pkg::IRQ_OVF_EN]);
  wire logic nxt_int_pin = int_pin_en ? (int_active ~^ int_pol) : !int_pol;

  // ==========================================================
  // read port
  wire logic [7:0] rd_mux =
      hit_pwr  ? pwr_ctrl_ff
    : (st_suspend | st_srst) ? 8'h00
    : hit_stat ? int_stat_ff
    : hit_mode ? mode_ctrl_ff
    : hit_irq  ? irq_en_ff
    : 8'h00;
  wire logic [7:0] nxt_rdata = reg_req.rd ? rd_mux : rdata_ff;

  // ==========================================================
  // flops
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pstate_ff     <= mmc_pkg::PS_SUSPEND;
      pwr_ctrl_ff   <= mmc_pkg::RST_PWR_CTRL;
      mode_ctrl_ff  <= mmc_pkg::RST_MODE_CTRL;
      irq_en_ff     <= mmc_pkg::RST_IRQ_EN;
      int_stat_ff   <= mmc_pkg::RST_INT_STAT;
      rdata_ff      <= 8'h00;
      rate_ff       <= 5'h0A;
      three_wire_ff <= 1'b0;
      int_pin_ff    <= 1'b0;
      rhall_ff      <= '0;
      spi_meta_ff   <= 1'b0;
      spi_sync_ff   <= 1'b0;
    end else if (ce) begin
      pstate_ff     <= nxt_pstate;
      pwr_ctrl_ff   <= nxt_pwr_ctrl;
      mode_ctrl_ff  <= nxt_mode_ctrl;
      irq_en_ff     <= nxt_irq_en;
      int_stat_ff   <= nxt_int_stat;
      rdata_ff      <= nxt_rdata;
      rate_ff       <= nxt_rate;
      three_wire_ff <= nxt_three_wire;
      int_pin_ff    <= nxt_int_pin;
      rhall_ff      <= nxt_rhall;
      spi_meta_ff   <= spi_sel_pin;
      spi_sync_ff   <= spi_meta_ff;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign suspended    = pstate_ff[0];
  assign op_mode      = mode_ctrl_ff[mmc_pkg::MODE_OP_LO +: 2];
  assign rate_hz      = rate_ff;
  assign adv_selftest = mode_ctrl_ff[mmc_pkg::MODE_ADV_LO +: 2];
  assign selftest     = mode_ctrl_ff[mmc_pkg::MODE_ST];
  assign three_wire   = three_wire_ff;
  assign rhall        = rhall_ff;
  assign int_pin      = int_pin_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  pwr_access_a: assert property (ce && st_suspend && wr_pwr && reg_req.wdata[0]
    |=> pwr_on and (ce |=> st_awake))
    else $error("power register write lost in suspend");

  soft_rst_a: assert property (ce && st_awake && pwr_on && trig_both |=> st_srst)
    else $error("soft reset not started on both triggers");

  srst_default_a: assert property (ce && st_srst && !wr_pwr |=>
    mode_ctrl_ff == mmc_pkg::RST_MODE_CTRL && irq_en_ff == mmc_pkg::RST_IRQ_EN
    && int_stat_ff == mmc_pkg::RST_INT_STAT
    && pwr_ctrl_ff[mmc_pkg::PWR_3W] == $past(pwr_ctrl_ff[mmc_pkg::PWR_3W])
    && pwr_on == $past(pwr_on))
    else $error("soft reset left a register off default");

  srst_sleep_a: assert property (ce && st_srst |=>
    op_mode == mmc_pkg::MMC_OP_SLEEP)
    else $error("soft reset did not end in sleep");

  srst_ignore_a: assert property (ce && st_suspend |=> !st_srst)
    else $error("soft reset ran from suspend");

  trig_clear_a: assert property (ce && st_srst |=> st_awake
    && !pwr_ctrl_ff[mmc_pkg::PWR_SRST_HI] && !pwr_ctrl_ff[mmc_pkg::PWR_SRST_LO])
    else $error("trigger bits not cleared after soft reset");

  three_wire_a: assert property (ce |=>
    three_wire == ($past(spi_sync_ff) & $past(pwr_ctrl_ff[mmc_pkg::PWR_3W])))
    else $error("three-wire select wrong");

  pwr_down_a: assert property (ce && st_awake && !pwr_on |=> st_suspend)
    else $error("power bit zero did not suspend");

  rate_map_a: assert property (ce |=> rate_hz == mmc_pkg::mmc_rate_hz($past(rate_code)))
    else $error("rate decode wrong");

  ovr_gate_a: assert property (ce && !irq_en_ff[mmc_pkg::IRQ_OVR_EN]
    && !(int_latch && int_stat_ff[mmc_pkg::STAT_OVR])
    |=> !int_stat_ff[mmc_pkg::STAT_OVR])
    else $error("overrun flagged while disabled");

  ovf_route_a: assert property (ce && int_pin_en && int_pol && (int_stat_ff[5:0] == 6'h00)
    && !irq_en_ff[mmc_pkg::IRQ_OVF_EN] |=> !int_pin)
    else $error("overflow reached pin while unrouted");

  axis_hold_a: assert property (ce && st_awake && chan_off[0] ##1 ce
    |-> $stable(data_axis[0]))
    else $error("disabled axis value changed");

  rhall_zero_a: assert property (ce && chan_off[2] |=> rhall == '0)
    else $error("resistance not zero with z off");

  pwr_fixed_a: assert property (pwr_ctrl_ff[6:3] == 4'h0)
    else $error("fixed power bits not zero");

  pwr_read_a: assert property (ce && reg_req.rd && hit_pwr
    |=> reg_rdata == $past(pwr_ctrl_ff))
    else $error("power register read wrong");

  susp_rd_zero_a: assert property (ce && reg_req.rd && st_suspend && !hit_pwr
    |=> reg_rdata == 8'h00)
    else $error("non-power register readable in suspend");

  trig_drop_a: assert property (ce && st_suspend
    |=> !pwr_ctrl_ff[mmc_pkg::PWR_SRST_HI] && !pwr_ctrl_ff[mmc_pkg::PWR_SRST_LO])
    else $error("trigger bits kept in suspend");

  mode_layout_a: assert property (ce && wr_mode
    |=> adv_selftest == $past(reg_req.wdata[7:6]) && rate_code == $past(reg_req.wdata[5:3])
    && op_mode == $past(reg_req.wdata[2:1]) && selftest == $past(reg_req.wdata[0]))
    else $error("mode register fields misplaced");

  rate_top_a: assert property (ce |=> (rate_hz == 5'h1E) == ($past(rate_code) == 3'h7))
    else $error("top rate code not 30 Hz");

  ovr_flag_a: assert property (ce && st_awake && overrun_evt
    && irq_en_ff[mmc_pkg::IRQ_OVR_EN] |=> int_stat_ff[mmc_pkg::STAT_OVR])
    else $error("enabled overrun not flagged");

  ovf_pin_a: assert property (ce && int_pin_en && int_pol
    && int_stat_ff[mmc_pkg::STAT_OVF] && irq_en_ff[mmc_pkg::IRQ_OVF_EN] |=> int_pin)
    else $error("routed overflow missed the pin");

  hi_gate_a: assert property (ce && !int_latch
    && irq_en_ff[mmc_pkg::IRQ_HI_LO +: 3] == 3'h7 |=> int_stat_ff[mmc_pkg::STAT_HI_LO +: 3] == 3'h0)
    else $error("disabled high threshold flagged");

  lo_gate_a: assert property (ce && !int_latch
    && irq_en_ff[mmc_pkg::IRQ_LO_LO +: 3] == 3'h7 |=> int_stat_ff[mmc_pkg::STAT_LO_LO +: 3] == 3'h0)
    else $error("disabled low threshold flagged");

  held_thr_a: assert property (ce && st_awake && !int_latch && chan_off[2]
    && hi_en[2] && above[2] |=> int_stat_ff[mmc_pkg::STAT_HI_LO + 2])
    else $error("threshold on disabled axis not flagged");

  ovf_flag_a: assert property (ce && st_awake && overflow_evt
    |=> int_stat_ff[mmc_pkg::STAT_OVF])
    else $error("overflow status bit not set");

  srst_done_c: cover property (st_awake ##1 st_srst ##1 st_awake);
  wake_c:      cover property (st_suspend ##1 st_awake);
  read_clr_c:  cover property (int_latch && int_stat_ff != 8'h00 && rd_stat ##1 int_stat_ff == 8'h00);
  forced_c:    cover property (st_awake && op_mode == mmc_pkg::MMC_OP_FORCED);
  ovr_set_c:   cover property (st_awake && int_stat_ff[mmc_pkg::STAT_OVR]);

endmodule : mmc_ctrl_regs
`default_nettype wire

// ==== core/mmc_pkg.sv ====
// ==========================================================
// register map and field layout
package mmc_pkg;

  localparam logic [7:0] ADDR_INT_STAT  = 8'h4A;
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h4B;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h4C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h4D;

  localparam logic [7:0] RST_PWR_CTRL   = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL  = 8'h06;
  localparam logic [7:0] RST_IRQ_EN     = 8'h3F;
  localparam logic [7:0] RST_INT_STAT   = 8'h00;

  // power_reset_iface_ctrl fields
  localparam int PWR_SRST_HI  = 7;
  localparam int PWR_3W       = 2;
  localparam int PWR_SRST_LO  = 1;
  localparam int PWR_ON       = 0;
  localparam logic [7:0] PWR_WR_MASK = 8'h87;

  // opmode_rate_selftest_ctrl fields
  localparam int MODE_ADV_LO  = 6;
  localparam int MODE_RATE_LO = 3;
  localparam int MODE_OP_LO   = 1;
  localparam int MODE_ST      = 0;

  // threshold_irq_enable_ctrl and status fields
  localparam int IRQ_OVR_EN   = 7;
  localparam int IRQ_OVF_EN   = 6;
  localparam int IRQ_HI_LO    = 3;
  localparam int IRQ_LO_LO    = 0;
  localparam int STAT_OVR     = 7;
  localparam int STAT_OVF     = 6;
  localparam int STAT_HI_LO   = 3;
  localparam int STAT_LO_LO   = 0;

  // ==========================================================
  // data path widths
  localparam int AXIS_W    = 15;
  localparam int RHALL_W   = 14;
  localparam int THR_W     = 8;
  localparam int THR_SHIFT = 4;
  localparam int RATE_W    = 5;

  typedef enum logic [1:0] {
    MMC_OP_NORMAL = 2'b00,
    MMC_OP_FORCED = 2'b01,
    MMC_OP_RSVD   = 2'b10,
    MMC_OP_SLEEP  = 2'b11
  } mmc_opmode_t;

  typedef enum logic [2:0] {
    PS_SUSPEND = 3'b001,
    PS_AWAKE   = 3'b010,
    PS_SRST    = 3'b100
  } mmc_pstate_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmc_reg_req_t;

  typedef struct packed {
    logic                         valid;
    logic [2:0][AXIS_W-1:0]       axis;
    logic [RHALL_W-1:0]           rhall;
  } mmc_meas_t;

  // output rate code to Hz
  function automatic logic [RATE_W-1:0] mmc_rate_hz(input logic [2:0] code);
    logic [RATE_W-1:0] hz;
    hz = 5'h0A;
    unique case (code)
      3'h0: hz = 5'h0A;
      3'h1: hz = 5'h02;
      3'h2: hz = 5'h06;
      3'h3: hz = 5'h08;
      3'h4: hz = 5'h0F;
      3'h5: hz = 5'h14;
      3'h6: hz = 5'h19;
      3'h7: hz = 5'h1E;
    endcase
    return hz;
  endfunction : mmc_rate_hz

endpackage : mmc_pkg

// ==== verif/mmc_ctrl_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmc_ctrl_regs_tb;
  logic                  clk_sys, reset_n, ce, spi_sel_pin, overrun_evt, overflow_evt;
  logic                  int_latch, int_pol, int_pin_en, suspended, selftest, three_wire;
  logic                  int_pin, rd_seen;
  logic [2:0]            chan_off;
  logic [7:0]            thr_low, thr_high, reg_rdata;
  logic [1:0]            op_mode, adv_selftest;
  logic [4:0]            rate_hz;
  logic [2:0][14:0]      data_axis;
  logic [13:0]           rhall;
  mmc_pkg::mmc_reg_req_t reg_req;
  mmc_pkg::mmc_meas_t    meas;
  logic [7:0]            exp_q[$];
  logic [31:0]           seed = 32'h0000C093;
  int                    mismatches = 0;
  int                    compares = 0;
  logic [4:0]            hz_tab [0:7] = '{5'h0A, 5'h02, 5'h06, 5'h08, 5'h0F, 5'h14, 5'h19, 5'h1E};
  logic [1:0]            md_tab [0:2] = '{2'b00, 2'b01, 2'b11};

  mmc_host_model u_host (.clk_sys, .reg_req);
  mmc_ctrl_regs u_dut (.clk_sys, .reset_n, .ce, .reg_req, .reg_rdata, .spi_sel_pin, .meas,
    .overrun_evt, .overflow_evt, .chan_off, .int_latch, .int_pol, .int_pin_en, .thr_low,
    .thr_high, .suspended, .op_mode, .rate_hz, .adv_selftest, .selftest, .three_wire,
    .data_axis, .rhall, .int_pin);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rd

  task automatic pulse(input logic ovr, input logic ovf);
    @(negedge clk_sys);
    overrun_evt = ovr;
    overflow_evt = ovf;
    @(negedge clk_sys);
    overrun_evt = 1'b0;
    overflow_evt = 1'b0;
  endtask : pulse

  task automatic send(input logic [14:0] x, y, z, input logic [13:0] rh);
    @(negedge clk_sys);
    meas = {1'b1, z, y, x, rh};
    @(negedge clk_sys);
    meas = {1'b0, ~z, ~y, ~x, ~rh};
  endtask : send

  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // ==========================================================
  // read monitor: oldest note against returned byte
  always @(posedge clk_sys) rd_seen <= reset_n && ce && reg_req.rd;
  always @(negedge clk_sys) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk("read_queue", 16'h0001, 16'h0000);
      else chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    logic [14:0] xv, yv, zv;
    reset_n = 1'b0;
    ce = 1'b1;
    spi_sel_pin = 1'b1;
    overrun_evt = 1'b0;
    overflow_evt = 1'b0;
    int_latch = 1'b0;
    int_pol = 1'b1;
    int_pin_en = 1'b1;
    chan_off = 3'h0;
    thr_low = 8'hFF;
    thr_high = 8'h01;
    meas = '0;
    idle(6);
    reset_n = 1'b1;
    chk("suspended", suspended, 16'h0001);
    chk("rate_hz", rate_hz, 16'h000A);
    rd(mmc_pkg::ADDR_MODE_CTRL, 8'h00);
    u_host.soft_reset(8'h00);
    idle(3);
    chk("suspended", suspended, 16'h0001);
    rd(mmc_pkg::ADDR_PWR_CTRL, 8'h00);
    u_host.wr(mmc_pkg::ADDR_PWR_CTRL, 8'h7D);
    idle(3);
    chk("suspended", suspended, 16'h0000);
    chk("three_wire", three_wire, 16'h0001);
    rd(mmc_pkg::ADDR_PWR_CTRL, 8'h05);
    rd(mmc_pkg::ADDR_MODE_CTRL, 8'h06);
    spi_sel_pin = 1'b0;
    idle(4);
    chk("three_wire", three_wire, 16'h0000);
    spi_sel_pin = 1'b1;
    done("suspend");
    for (int i = 0; i < 8; i++) begin
      r = xs();
      d = {r[1:0], 3'(i), md_tab[i % 3], r[2]};
      u_host.wr(mmc_pkg::ADDR_MODE_CTRL, d);
      idle(3);
      chk("rate_hz", rate_hz, hz_tab[i]);
      chk("op_mode", op_mode, md_tab[i % 3]);
      chk("adv_selftest", adv_selftest, r[1:0]);
      chk("selftest", selftest, r[2]);
      rd(mmc_pkg::ADDR_MODE_CTRL, d);
    end
    u_host.wr(mmc_pkg::ADDR_IRQ_EN, 8'hA5);
    rd(mmc_pkg::ADDR_IRQ_EN, 8'hA5);
    rd(8'h4F, 8'h00);
    done("mode");
    u_host.soft_reset(8'h05);
    idle(4);
    rd(mmc_pkg::ADDR_PWR_CTRL, 8'h05);
    rd(mmc_pkg::ADDR_MODE_CTRL, 8'h06);
    rd(mmc_pkg::ADDR_IRQ_EN, 8'h3F);
    chk("op_mode", op_mode, 16'h0003);
    chk("three_wire", three_wire, 16'h0001);
    u_host.wr(mmc_pkg::ADDR_MODE_CTRL, 8'h08);
    u_host.wr(mmc_pkg::ADDR_PWR_CTRL, 8'h85);
    idle(4);
    rd(mmc_pkg::ADDR_MODE_CTRL, 8'h08);
    rd(mmc_pkg::ADDR_PWR_CTRL, 8'h85);
    u_host.wr(mmc_pkg::ADDR_PWR_CTRL, 8'h05);
    done("soft_reset");
    r = xs();
    xv = {{2{r[12]}}, r[12:0]};
    yv = {{2{r[28]}}, r[28:16]};
    zv = r[30:16];
    send(xv, yv, zv, r[13:0]);
    idle(1);
    chk("data_x", data_axis[0], xv);
    chk("data_y", data_axis[1], yv);
    chk("data_z", data_axis[2], zv);
    chk("rhall", rhall, r[13:0]);
    u_host.wr(mmc_pkg::ADDR_IRQ_EN, 8'h00);
    send(15'h7F00, 15'h0000, 15'h0100, 14'h0155);
    idle(4);
    rd(mmc_pkg::ADDR_INT_STAT, 8'h21);
    chk("int_pin", int_pin, 16'h0001);
    chan_off = 3'b100;
    send(15'h0000, 15'h0000, 15'h0000, 14'h0AAA);
    idle(4);
    chk("data_z", data_axis[2], 16'h0100);
    chk("data_x", data_axis[0], 16'h0000);
    chk("rhall", rhall, 16'h0000);
    rd(mmc_pkg::ADDR_INT_STAT, 8'h20);
    done("measure");
    chan_off = 3'h0;
    u_host.wr(mmc_pkg::ADDR_IRQ_EN, 8'h3F);
    idle(1);
    int_latch = 1'b1;
    pulse(1'b1, 1'b0);
    idle(5);
    rd(mmc_pkg::ADDR_INT_STAT, 8'h00);
    pulse(1'b0, 1'b1);
    idle(5);
    chk("int_pin", int_pin, 16'h0000);
    rd(mmc_pkg::ADDR_INT_STAT, 8'h40);
    rd(mmc_pkg::ADDR_INT_STAT, 8'h00);
    u_host.wr(mmc_pkg::ADDR_IRQ_EN, 8'hFF);
    pulse(1'b1, 1'b1);
    idle(5);
    chk("int_pin", int_pin, 16'h0001);
    rd(mmc_pkg::ADDR_INT_STAT, 8'hC0);
    done("status");
    u_host.full_reset();
    idle(3);
    chk("three_wire", three_wire, 16'h0000);
    rd(mmc_pkg::ADDR_IRQ_EN, 8'h3F);
    idle(2);
    done("power_cycle");
    summarize();
  end
endmodule : mmc_ctrl_regs_tb
`default_nettype wire

// ==== verif/mmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side: single byte register master, pulses at falling edge
module mmc_host_model (
  input  wire logic                 clk_sys,
  output var  mmc_pkg::mmc_reg_req_t reg_req
);
  initial reg_req = '0;

  // released lines show inverted leftovers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = {w, !w, a, d};
    @(negedge clk_sys);
    reg_req = {1'b0, 1'b0, ~a, ~d};
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == mmc_pkg::ADDR_MODE_CTRL && d[2:1] == 2'b10) v[2:1] = 2'b11;
    xfer(1'b1, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask : rd

  // both trigger bits in one write
  task automatic soft_reset(input logic [7:0] keep);
    wr(mmc_pkg::ADDR_PWR_CTRL, keep | 8'h82);
  endtask : soft_reset

  // suspend then wake
  task automatic full_reset();
    wr(mmc_pkg::ADDR_PWR_CTRL, 8'h00);
    wr(mmc_pkg::ADDR_PWR_CTRL, 8'h01);
  endtask : full_reset
endmodule : mmc_host_model
`default_nettype wire
